//--- shared/cmbe_regs.svh
`ifndef CMBE_REGS_SVH
`define CMBE_REGS_SVH
// register offsets (word addresses on the plain port)
`define CMBE_A_CTRL 8'h00
`define CMBE_A_INTF 8'h01
`define CMBE_A_ERRCNT 8'h02
`define CMBE_A_TIMING 8'h03
`define CMBE_A_MASK0 8'h04
`define CMBE_A_FILT0 8'h05
`define CMBE_A_MASK1 8'h06
`define CMBE_A_FILT1 8'h07
`define CMBE_A_TXCON0 8'h08
`define CMBE_A_RXDATA0 8'h0c
`define CMBE_A_RXDATA1 8'h0d
`define CMBE_A_RXACK 8'h0e
// control register fields
`define CMBE_CTRL_ABORT_ALL 12
`define CMBE_CTRL_DOUBLE_BUFFER_ENABLE 0
`define CMBE_CTRL_CKS 1
`define CMBE_CTRL_TXIE 2
// interrupt flag register fields
`define CMBE_INTF_RX0 0
`define CMBE_INTF_RX1 1
`define CMBE_INTF_TX0 2
`define CMBE_INTF_ERR 5
`define CMBE_INTF_WAKE 6
`define CMBE_INTF_IVR 7
`define CMBE_INTF_RECEIVE_WARNING_FLAG 9
`define CMBE_INTF_TRANSMIT_WARNING_FLAG 10
`define CMBE_INTF_RECEIVE_PASSIVE_FLAG 11
`define CMBE_INTF_TRANSMIT_PASSIVE_FLAG 12
`define CMBE_INTF_BUS_OFF_FLAG 13
`define CMBE_INTF_OVR1 14
`define CMBE_INTF_OVR0 15
// transmit control fields
`define CMBE_TX_ABT 6
`define CMBE_TX_LARB 5
`define CMBE_TX_ERR 4
`define CMBE_TX_REQ 3
// error limits
`define CMBE_WARN_LIMIT 9'd96
`define CMBE_PASSIVE_LIMIT 9'd127
`define CMBE_BUSOFF_LIMIT 9'd255
// bit time limits in quanta
`define CMBE_TQ_MIN 5'd8
`define CMBE_TQ_MAX 5'd25
`endif

//--- shared/cmbe_pkg.sv
package cmbe_pkg;
    // one transmit buffer: 8 data bytes plus 5 identifier bytes
    typedef struct packed {
        logic [39:0] ident;
        logic [63:0] data;
        logic [1:0] pri;
        logic req;
        logic err;
        logic larb;
        logic abt;
    } cmbe_txbuf_t;
    // a message from the protocol engine
    typedef struct packed {
        logic [28:0] ident;
        logic [63:0] data;
    } cmbe_msg_t;
    // engine events toward this block
    typedef struct packed {
        logic rx_done;
        logic rx_crc_err;
        logic rx_stuff_err;
        logic rx_invalid;
        logic tx_ack_err;
        logic tx_form_err;
        logic tx_bit_err;
        logic tx_ok;
        logic tx_lost;
        logic tx_active;
        logic wake;
    } cmbe_ev_t;
    typedef enum logic [1:0] {CMBE_IDLE, CMBE_SEND, CMBE_DONE} cmbe_tx_st_t;
    // all state of the engine except the registered flag summary
    typedef struct packed {
        cmbe_txbuf_t [2:0] tx;
        cmbe_msg_t [1:0] rx;
        logic [1:0] receive_full_flag;
        logic [15:0] intf;
        logic [28:0] mask0, filt0, mask1, filt1;
        logic [2:0] ctrl;
        logic [8:0] rerr, terr;
        logic [5:0] prescaler_field;
        logic [2:0] propagation_length_field, seg1, seg2;
        logic [1:0] cur;
        cmbe_tx_st_t st;
        logic [6:0] pcnt;
        logic [4:0] qcnt;
        logic tq_tick, bit_tick;
        logic [31:0] rdata;
        logic start;
        cmbe_txbuf_t out;
    } cmbe_state_t;
endpackage : cmbe_pkg

//--- hw/cmbe_engine.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`include "cmbe_regs.svh"

// Notes on behaviour
// (R1) per-buffer mask; zero bit always matches
// (R2) full target buffer: drop, flag overrun, error
// (R3) no double buffering: buffers independent
// (R4) double buffering: overflow zero into one
// (R5) both full: drop, overrun on one
// (R6) receive errors count up by one
// (R7) warning at 96, passive above 127
// (R8) receive flag per buffer after frame
// (R9) wake-up raises wake flag
// (R10) any receive error sets invalid flag
// (R11) three transmit buffers, 13 bytes payload
// (R12) two-bit priority, three highest
// (R13) request clears aborted, lost, error flags
// (R14) send highest pending priority at start
// (R15) success clears request, flags buffer; here buffer zero is flagged only while TXIE is set
// (R16) failure keeps request, sets error/lost
// (R17) abort only when not actively sending
// (R18) transmit errors count; warning above 96
// (R19) buffer flag when sending frees buffer; here buffer zero is flagged only while TXIE is set
// (R20) passive above 127, bus-off above 255
// (R21) bit time eight to twenty-five quanta
// (R22) divide-by-two plus prescaler 1..64
// (R23) quantum is 2*(prescaler+1) clocks
// (R24) propagation length one to eight quanta
module cmbe_engine (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // protocol engine side
    input wire cmbe_pkg::cmbe_ev_t ev,
    input wire cmbe_pkg::cmbe_msg_t rx_msg,
    output cmbe_pkg::cmbe_txbuf_t tx_out,
    output logic tx_start,
    output logic tq_tick,
    output logic bit_tick,
    // status
    output logic irq_flags_any
);
    cmbe_pkg::cmbe_state_t q, d; // state except flag_any_q, and its next value
    logic [2:0] abort_ok; // per buffer abort acceptance
    logic [1:0] best; // highest priority pending buffer
    logic any_pend; // some buffer waiting
    logic hit0, hit1; // acceptance results
    logic any_rx_err, any_tx_err; // error strobes
    logic [4:0] raw_len; // bit length as programmed
    logic [4:0] bit_len; // nominal bit length in quanta
    logic [6:0] pdiv; // clocks per quantum minus one
    logic flag_any_q; // registered flag summary

    // acceptance: mask zero bits always match [R1]
    assign hit0 = ((rx_msg.ident ^ q.filt0) & q.mask0) == 29'h0000000; // [R1]
    assign hit1 = ((rx_msg.ident ^ q.filt1) & q.mask1) == 29'h0000000; // [R1]
    assign any_rx_err = ev.rx_crc_err | ev.rx_stuff_err | ev.rx_invalid;
    assign any_tx_err = ev.tx_ack_err | ev.tx_form_err | ev.tx_bit_err;
    // sync 1 + prop + seg1 + seg2, each field one less than quanta [R21] [R24]
    assign raw_len = 5'd4 + {2'b00, q.propagation_length_field} + {2'b00, q.seg1} + {2'b00, q.seg2};
    // short settings are stretched to the minimum; the maximum is reached by construction
    assign bit_len = (raw_len < `CMBE_TQ_MIN) ? `CMBE_TQ_MIN : raw_len; // [R21]
    // fixed divide by two times (prescaler + 1) [R22] [R23]
    assign pdiv = {q.prescaler_field, 1'b1};

    // priority pick, lowest index wins ties [R12] [R14]
    always_comb begin
        best = 2'd0;
        any_pend = 1'b0;
        for (int i = 2; i >= 0; i--) begin
            if (q.tx[i].req && (!any_pend || q.tx[i].pri >= q.tx[best].pri)) begin // [R12]
                best = 2'(i);
                any_pend = 1'b1;
            end
        end
    end

    // abort only while buffer is not on the bus [R17]
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            abort_ok[i] = !(q.st == cmbe_pkg::CMBE_SEND && q.cur == 2'(i) && ev.tx_active); // [R17]
        end
    end

    // next state
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.tq_tick = 1'b0;
        d.bit_tick = 1'b0;
        d.rdata = 32'h00000000;
        // quantum and bit timing from the prescaler
        if (q.pcnt >= pdiv) begin
            d.pcnt = 7'h00;
            d.tq_tick = 1'b1; // [R22]
            if (q.qcnt >= bit_len - 5'd1) begin
                d.qcnt = 5'h00;
                d.bit_tick = 1'b1; // [R21]
            end else begin
                d.qcnt = q.qcnt + 5'd1;
            end
        end else begin
            d.pcnt = q.pcnt + 7'd1;
        end
        // register reads: data stand in the following cycle
        if (rd) begin
            case (addr)
                `CMBE_A_CTRL: d.rdata = {29'h0, q.ctrl};
                `CMBE_A_INTF: d.rdata = {16'h0, q.intf};
                `CMBE_A_ERRCNT: d.rdata = {7'h0, q.terr, 7'h0, q.rerr};
                `CMBE_A_TIMING: d.rdata = {16'h0, q.seg2, q.seg1, q.prescaler_field, 1'b0, q.propagation_length_field};
                `CMBE_A_MASK0: d.rdata = {3'h0, q.mask0};
                `CMBE_A_FILT0: d.rdata = {3'h0, q.filt0};
                `CMBE_A_MASK1: d.rdata = {3'h0, q.mask1};
                `CMBE_A_FILT1: d.rdata = {3'h0, q.filt1};
                `CMBE_A_TXCON0, 8'h09, 8'h0a: begin
                    d.rdata = {25'h0, q.tx[addr[1:0]].abt, q.tx[addr[1:0]].larb,
                               q.tx[addr[1:0]].err, q.tx[addr[1:0]].req, 1'b0, q.tx[addr[1:0]].pri};
                end
                `CMBE_A_RXDATA0: d.rdata = q.rx[0].data[31:0];
                `CMBE_A_RXDATA1: d.rdata = q.rx[1].data[31:0];
                `CMBE_A_RXACK: d.rdata = {30'h0, q.receive_full_flag};
                default: d.rdata = 32'h00000000; // unmapped reads zero
            endcase
        end
        // register writes
        if (wr) begin
            case (addr)
                `CMBE_A_CTRL: begin
                    d.ctrl = wdata[2:0];
                    if (wdata[`CMBE_CTRL_ABORT_ALL]) begin
                        for (int i = 0; i < 3; i++) begin
                            if (q.tx[i].req && abort_ok[i]) begin // [R17]
                                d.tx[i].req = 1'b0;
                                d.tx[i].abt = 1'b1; // [R17]
                            end
                        end
                    end
                end
                `CMBE_A_INTF: d.intf = q.intf & wdata[15:0]; // write zero clears
                `CMBE_A_TIMING: begin
                    d.propagation_length_field = wdata[2:0]; // [R24]
                    d.prescaler_field = wdata[9:4]; // [R23]
                    d.seg1 = wdata[12:10];
                    d.seg2 = wdata[15:13] == 3'd0 ? 3'd1 : wdata[15:13];
                end
                `CMBE_A_MASK0: d.mask0 = wdata[28:0]; // [R1]
                `CMBE_A_FILT0: d.filt0 = wdata[28:0];
                `CMBE_A_MASK1: d.mask1 = wdata[28:0]; // [R1]
                `CMBE_A_FILT1: d.filt1 = wdata[28:0];
                `CMBE_A_TXCON0, 8'h09, 8'h0a: begin
                    d.tx[addr[1:0]].pri = wdata[1:0]; // [R12]
                    if (wdata[`CMBE_TX_REQ] && !q.tx[addr[1:0]].req) begin
                        d.tx[addr[1:0]].req = 1'b1;
                        d.tx[addr[1:0]].abt = 1'b0; // [R13]
                        d.tx[addr[1:0]].larb = 1'b0; // [R13]
                        d.tx[addr[1:0]].err = 1'b0; // [R13]
                    end else if (!wdata[`CMBE_TX_REQ] && q.tx[addr[1:0]].req) begin
                        if (abort_ok[addr[1:0]]) begin // [R17]
                            d.tx[addr[1:0]].req = 1'b0;
                            d.tx[addr[1:0]].abt = 1'b1;
                        end
                    end
                end
                8'h10, 8'h11, 8'h12: d.tx[addr[1:0]].data[31:0] = wdata; // [R11]
                8'h14, 8'h15, 8'h16: d.tx[addr[1:0]].data[63:32] = wdata; // [R11]
                8'h18, 8'h19, 8'h1a: d.tx[addr[1:0]].ident[31:0] = wdata; // [R11]
                8'h1c, 8'h1d, 8'h1e: d.tx[addr[1:0]].ident[39:32] = wdata[7:0]; // [R11]
                `CMBE_A_RXACK: d.receive_full_flag = q.receive_full_flag & ~wdata[1:0]; // write one releases buffer
                default: ;
            endcase
        end
        // transmit sequencing; set from the engine beats the clears above
        case (q.st)
            cmbe_pkg::CMBE_IDLE: begin
                if (any_pend && q.bit_tick && !q.intf[`CMBE_INTF_BUS_OFF_FLAG]) begin
                    d.cur = best; // priority resolved at start of frame [R14]
                    d.out = q.tx[best];
                    d.start = 1'b1;
                    d.st = cmbe_pkg::CMBE_SEND;
                end
            end
            cmbe_pkg::CMBE_SEND: begin
                if (ev.tx_ok) begin
                    d.tx[q.cur].req = 1'b0; // [R15]
                    d.st = cmbe_pkg::CMBE_DONE;
                end else if (any_tx_err) begin
                    d.tx[q.cur].err = 1'b1; // request kept [R16]
                    d.intf[`CMBE_INTF_ERR] = 1'b1; // [R16]
                    d.st = cmbe_pkg::CMBE_IDLE;
                end else if (ev.tx_lost) begin
                    d.tx[q.cur].larb = 1'b1; // no interrupt [R16]
                    d.st = cmbe_pkg::CMBE_IDLE;
                end else if (!q.tx[q.cur].req) begin
                    d.st = cmbe_pkg::CMBE_IDLE; // aborted before bus activity
                end
            end
            cmbe_pkg::CMBE_DONE: d.st = cmbe_pkg::CMBE_IDLE;
            default: d.st = cmbe_pkg::CMBE_IDLE;
        endcase
        // flag a buffer freed by a finished send, buffer zero only while TXIE is set; an abort frees it silently [R19] [R17]
        for (int i = 0; i < 3; i++) begin
            if (q.tx[i].req && !d.tx[i].req && !d.tx[i].abt && (q.ctrl[`CMBE_CTRL_TXIE] || i != 0)) begin
                d.intf[`CMBE_INTF_TX0 + i] = 1'b1; // [R15] [R19]
            end
        end
        // transmit error counter [R18]
        if (any_tx_err && q.terr <= `CMBE_BUSOFF_LIMIT) begin
            d.terr = q.terr + 9'd1; // [R18]
        end
        if (d.terr > `CMBE_WARN_LIMIT) begin
            d.intf[`CMBE_INTF_TRANSMIT_WARNING_FLAG] = 1'b1; // [R18]
            d.intf[`CMBE_INTF_ERR] = 1'b1; // [R18]
        end
        if (d.terr > `CMBE_PASSIVE_LIMIT) d.intf[`CMBE_INTF_TRANSMIT_PASSIVE_FLAG] = 1'b1; // [R20]
        if (d.terr > `CMBE_BUSOFF_LIMIT) d.intf[`CMBE_INTF_BUS_OFF_FLAG] = 1'b1; // [R20]
        // receive error counter [R6]
        if (any_rx_err) begin
            if (q.rerr < 9'h1ff) d.rerr = q.rerr + 9'd1; // [R6]
            d.intf[`CMBE_INTF_IVR] = 1'b1; // [R10]
            d.intf[`CMBE_INTF_ERR] = 1'b1; // [R10]
        end
        if (d.rerr >= `CMBE_WARN_LIMIT) d.intf[`CMBE_INTF_RECEIVE_WARNING_FLAG] = 1'b1; // [R7]
        if (d.rerr > `CMBE_PASSIVE_LIMIT) d.intf[`CMBE_INTF_RECEIVE_PASSIVE_FLAG] = 1'b1; // [R7]
        // wake-up [R9]
        if (ev.wake) d.intf[`CMBE_INTF_WAKE] = 1'b1; // [R9]
        // receive store at end of frame; buffer zero first
        if (ev.rx_done && !any_rx_err) begin
            if (hit0) begin
                if (!q.receive_full_flag[0]) begin
                    d.rx[0] = rx_msg;
                    d.receive_full_flag[0] = 1'b1;
                    d.intf[`CMBE_INTF_RX0] = 1'b1; // [R8]
                end else if (q.ctrl[`CMBE_CTRL_DOUBLE_BUFFER_ENABLE] && !q.receive_full_flag[1]) begin
                    d.rx[1] = rx_msg; // [R4]
                    d.receive_full_flag[1] = 1'b1;
                    d.intf[`CMBE_INTF_RX1] = 1'b1; // [R8]
                end else if (q.ctrl[`CMBE_CTRL_DOUBLE_BUFFER_ENABLE]) begin
                    d.intf[`CMBE_INTF_OVR1] = 1'b1; // [R5]
                    d.intf[`CMBE_INTF_ERR] = 1'b1; // [R2]
                end else begin
                    d.intf[`CMBE_INTF_OVR0] = 1'b1; // [R3]
                    d.intf[`CMBE_INTF_ERR] = 1'b1; // [R2]
                end
            end else if (hit1) begin
                if (!q.receive_full_flag[1]) begin
                    d.rx[1] = rx_msg;
                    d.receive_full_flag[1] = 1'b1;
                    d.intf[`CMBE_INTF_RX1] = 1'b1; // [R8]
                end else begin
                    d.intf[`CMBE_INTF_OVR1] = 1'b1; // [R2]
                    d.intf[`CMBE_INTF_ERR] = 1'b1; // [R2]
                end
            end
        end
    end

    // state register; synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.mask0 <= 29'h1fffffff;
            q.mask1 <= 29'h1fffffff;
            q.seg1 <= 3'd2;
            q.seg2 <= 3'd2;
            flag_any_q <= 1'b0;
        end else begin
            q <= d;
            flag_any_q <= |d.intf;
        end
    end

    // outputs straight from flops
    assign rdata = q.rdata;
    assign tx_out = q.out;
    assign tx_start = q.start;
    assign tq_tick = q.tq_tick;
    assign bit_tick = q.bit_tick;
    assign irq_flags_any = flag_any_q;
endmodule : cmbe_engine

//--- tb/cmbe_engine_assertions.sv
module cmbe_engine_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic rd,
    input wire logic [31:0] rdata,
    // engine side
    input wire cmbe_pkg::cmbe_ev_t ev,
    input wire cmbe_pkg::cmbe_txbuf_t tx_out,
    input wire logic tx_start,
    input wire logic tq_tick,
    input wire logic bit_tick,
    input wire logic irq_flags_any
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // read data only in the slot after a read
    a_rdata_slot_only: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its slot");
    // fixed divide-by-two keeps quanta two clocks apart
    a_quantum_gap: assert property (tq_tick |=> !tq_tick)
        else $error("quantum shorter than two clocks");
    // eight quanta at least, so sixteen clocks at least
    a_bit_min_len: assert property (bit_tick |=> !bit_tick [*8])
        else $error("bit time too short");
    // bit boundaries fall on quantum boundaries
    a_bit_on_quantum: assert property (bit_tick |-> tq_tick || $past(tq_tick))
        else $error("bit edge off quantum");
    // frames start only at a bit boundary
    a_start_on_bit: assert property (tx_start |-> bit_tick || $past(bit_tick))
        else $error("start off bit boundary");
    // the snapshot sent is a queued buffer
    a_start_queued: assert property (tx_start |-> tx_out.req)
        else $error("start of unqueued buffer");
    // one attempt at most per bit
    a_start_spacing: assert property (tx_start |=> !tx_start [*8])
        else $error("starts too close");
    // wake-up flag reaches the summary output
    a_wake_flags: assert property (ev.wake |-> ##[1:2] irq_flags_any)
        else $error("wake not flagged");
    // a crc receive error reaches the summary output
    a_rxerr_flags: assert property (ev.rx_crc_err |-> ##[1:2] irq_flags_any)
        else $error("receive error not flagged");
endmodule : cmbe_engine_checker

bind cmbe_engine cmbe_engine_checker cmbe_engine_checker_inst (.clk(clk), .rst_n(rst_n), .rd(rd),
    .rdata(rdata), .ev(ev), .tx_out(tx_out), .tx_start(tx_start), .tq_tick(tq_tick),
    .bit_tick(bit_tick), .irq_flags_any(irq_flags_any));

//--- tb/cmbe_peer.sv
module cmbe_peer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench commands
    input wire logic go,
    input wire logic [2:0] cmd,
    input wire logic [28:0] id,
    input wire logic [2:0] tx_mode,
    // engine side
    input wire logic tx_start,
    output cmbe_pkg::cmbe_ev_t ev = '0,
    output cmbe_pkg::cmbe_msg_t rx_msg = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left_q = 4'h0; // cycles left in an attempt
    // events are one-cycle pulses except tx_active, which is held; payload toggles when not valid
    always @(posedge clk) begin
        ev <= '0;
        ev.tx_active <= ev.tx_active;
        rx_msg <= ~rx_msg;
        if (!rst_n) begin
            ev.tx_active <= 1'b0;
            left_q <= 4'h0;
        end else begin
            // bench-ordered receive events
            if (go) begin
                ev.rx_done <= cmd == 3'h0;
                ev.rx_crc_err <= cmd == 3'h1;
                ev.rx_stuff_err <= cmd == 3'h2;
                ev.rx_invalid <= cmd == 3'h3;
                ev.wake <= cmd == 3'h4;
                rx_msg <= {id, {2{3'h0, id}}};
            end
            // bus held for a few cycles, then the outcome
            if (tx_start) begin
                ev.tx_active <= 1'b1;
                left_q <= 4'h6;
            end else if (left_q != 4'h0) begin
                left_q <= left_q - 4'h1;
                if (left_q == 4'h1) begin
                    ev.tx_active <= 1'b0;
                    ev.tx_ok <= tx_mode == 3'h0;
                    ev.tx_lost <= tx_mode == 3'h1;
                    ev.tx_ack_err <= tx_mode == 3'h2;
                    ev.tx_form_err <= tx_mode == 3'h3;
                    ev.tx_bit_err <= tx_mode == 3'h4;
                end
            end
        end
    end
endmodule : cmbe_peer

//--- tb/cmbe_engine_test.sv
module cmbe_engine_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    cmbe_pkg::cmbe_ev_t ev;
    cmbe_pkg::cmbe_msg_t rx_msg;
    cmbe_pkg::cmbe_txbuf_t tx_out;
    logic tx_start;
    logic tq_tick;
    logic bit_tick;
    logic irq_flags_any;
    // partner commands
    logic go = 1'b0;
    logic [2:0] cmd = 3'h0;
    logic [28:0] id = 29'h0;
    logic [2:0] tx_mode = 3'h0;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    cmbe_engine cmbe_engine_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ev(ev), .rx_msg(rx_msg), .tx_out(tx_out), .tx_start(tx_start),
        .tq_tick(tq_tick), .bit_tick(bit_tick), .irq_flags_any(irq_flags_any));
    cmbe_peer cmbe_peer_inst (.clk(clk), .rst_n(rst_n), .go(go), .cmd(cmd), .id(id),
        .tx_mode(tx_mode), .tx_start(tx_start), .ev(ev), .rx_msg(rx_msg));
    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // strobes drop a cycle after use, so calls never collide
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask : rd_reg
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        rd_reg(a, v);
        chk($sformatf("reg %h", a), e, v & m);
    endtask : rc
    task automatic peer(input logic [2:0] c, input logic [28:0] i);
        cmd <= c;
        id <= i;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : peer
    // crc, stuffing and invalid errors in turn
    task automatic rx_errs(input int n);
        for (int k = 0; k < n; k++) peer(3'(1 + k % 3), 29'h0);
    endtask : rx_errs
    function automatic logic tick(input bit b);
        return b ? bit_tick : tq_tick;
    endfunction : tick
    // skip one period so a fresh setting is measured
    task automatic gap(input bit b, input int e);
        int n;
        n = 0;
        repeat (2) begin
            @(posedge clk);
            while (tick(b) !== 1'b1) @(posedge clk);
        end
        do begin
            @(posedge clk);
            n++;
        end while (tick(b) !== 1'b1 && n < 99);
        chk("tick gap", e, n);
    endtask : gap
    task automatic align;
        while (bit_tick !== 1'b1) @(posedge clk);
    endtask : align
    task automatic wait_start(input logic [1:0] p);
        int k;
        k = 0;
        @(posedge clk);
        while (tx_start !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        chk("start seen", 32'h1, {31'h0, tx_start});
        chk("sent priority", {30'h0, p}, {30'h0, tx_out.pri});
    endtask : wait_start
    // rotate acknowledge, form and bit errors until bus-off
    task automatic bus_off;
        logic [31:0] v;
        v = 32'h0;
        for (int k = 0; k < 6000 && v[13] !== 1'b1; k++) begin
            tx_mode <= 3'(2 + k % 3);
            rd_reg(8'h01, v);
        end
    endtask : bus_off
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(8'h04, 32'hffffffff, 32'h1fffffff);
        rc(8'h3f, 32'hffffffff, 32'h0);
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h05, 32'h1555);
        peer(3'h0, 29'haaa);
        rc(8'h01, 32'h3, 32'h1);
        rc(8'h0c, 32'hffffffff, 32'haaa);
        peer(3'h0, 29'hbbb);
        rc(8'h01, 32'h8022, 32'h8020);
        rc(8'h0c, 32'hffffffff, 32'haaa);
        wr_reg(8'h01, 32'h0);
        wr_reg(8'h00, 32'h5);
        peer(3'h0, 29'hccc);
        rc(8'h01, 32'hc002, 32'h2);
        rc(8'h0d, 32'hffffffff, 32'hccc);
        peer(3'h0, 29'hddd);
        rc(8'h01, 32'hc000, 32'h4000);
        rx_errs(95);
        rc(8'h02, 32'h1ff01ff, 32'd95);
        rc(8'h01, 32'h280, 32'h80);
        rx_errs(1);
        rc(8'h01, 32'h200, 32'h200);
        rx_errs(31);
        rc(8'h01, 32'h800, 32'h0);
        rx_errs(1);
        rc(8'h01, 32'h800, 32'h800);
        peer(3'h4, 29'h0);
        rc(8'h01, 32'h40, 32'h40);
        wr_reg(8'h03, 32'h4810);
        gap(1'b0, 4);
        gap(1'b1, 32);
        wr_reg(8'h03, 32'h4817);
        gap(1'b1, 60);
        wr_reg(8'h03, 32'h10);
        gap(1'b1, 32);
        wr_reg(8'h03, 32'h4810);
        align();
        wr_reg(8'h09, 32'h9);
        wr_reg(8'h0a, 32'hb);
        wait_start(2'b11);
        wait_start(2'b01);
        repeat (10) @(posedge clk);
        rc(8'h0a, 32'h8, 32'h0);
        wr_reg(8'h10, 32'h5a5a1234);
        wr_reg(8'h1c, 32'ha5);
        wr_reg(8'h08, 32'h8);
        wait_start(2'b00);
        wr_reg(8'h08, 32'h0);
        chk("sent data", 32'h5a5a1234, tx_out.data[31:0]);
        chk("sent ident", 32'ha5, {24'h0, tx_out.ident[39:32]});
        repeat (10) @(posedge clk);
        rc(8'h08, 32'h48, 32'h0);
        rc(8'h01, 32'h4, 32'h4);
        wr_reg(8'h01, 32'h0);
        tx_mode <= 3'h1;
        wr_reg(8'h08, 32'h8);
        wait_start(2'b00);
        repeat (8) @(posedge clk);
        rc(8'h08, 32'h38, 32'h28);
        wr_reg(8'h08, 32'h0);
        rc(8'h08, 32'h78, 32'h60);
        rc(8'h01, 32'h4, 32'h0);
        tx_mode <= 3'h2;
        align();
        wr_reg(8'h08, 32'h8);
        rc(8'h08, 32'h78, 32'h8);
        wait_start(2'b00);
        repeat (8) @(posedge clk);
        rc(8'h08, 32'h18, 32'h18);
        bus_off();
        rc(8'h01, 32'h3420, 32'h3420);
        rc(8'h02, 32'h1000000, 32'h1000000);
        align();
        repeat (10) @(posedge clk);
        wr_reg(8'h00, 32'h1005);
        rc(8'h08, 32'h48, 32'h40);
        tally_and_finish();
    end
endmodule : cmbe_engine_test
